// file: rtl/sac_adc_ctrl.v
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_adc_ctrl
(
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [79:0] ain_code,
    input wire [9:0] ref_ext_code,
    input wire global_irq_enable,
    input wire irq_vector_ack,
    output reg conversion_done_irq,
    output reg internal_ref_on,
    output reg [3:0] mux_chan_out,
    output reg [1:0] mux_ref_out
);
    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    reg [1:0] reference_select_q;
    reg left_justify_q;
    reg [3:0] channel_select_q;
    reg converter_on_q;
    reg convert_go_q;
    reg free_run_select_q;
    reg conversion_done_flag_q;
    reg conversion_done_irq_enable_q;
    reg [2:0] prescale_select_q;
    reg [9:0] result_q;
    reg pend_valid_q;
    reg lock_q;
    reg first_q;
    reg busy_q;
    reg [4:0] cnt_q;
    reg [3:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    wire tick;
    wire [9:0] core_code;
    reg core_sample_q;
    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    function [7:0] read_reg;
        input [3:0] addr;
        begin
            read_reg = `SAC_RST_BYTE;
            if (addr == `SAC_ADDR_MUX)
                read_reg = {reference_select_q, left_justify_q, 1'b0,
                    channel_select_q};
            else if (addr == `SAC_ADDR_CSR)
                read_reg = {converter_on_q, convert_go_q, free_run_select_q,
                    conversion_done_flag_q, conversion_done_irq_enable_q,
                    prescale_select_q};
            else if (addr == `SAC_ADDR_RLO)
                read_reg = left_justify_q ? {result_q[1:0], 6'h00}
                    : result_q[7:0];
            else if (addr == `SAC_ADDR_RHI)
                read_reg = left_justify_q ? result_q[9:2]
                    : {6'h00, result_q[9:8]};
        end
    endfunction
    function mapped;
        input [3:0] addr;
        begin
            mapped = (addr == `SAC_ADDR_MUX) || (addr == `SAC_ADDR_CSR) ||
                (addr == `SAC_ADDR_RLO) || (addr == `SAC_ADDR_RHI);
        end
    endfunction
    //--------------------------------------------------------------
    // Leaf instances
    //--------------------------------------------------------------
    sac_prescaler u_pre
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(converter_on_q),
        .sel(prescale_select_q),
        .tick(tick)
    );
    sac_core_model u_core
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample(core_sample_q),
        .chan(mux_chan_out),
        .refsel(mux_ref_out),
        .ain_code(ain_code),
        .ref_ext_code(ref_ext_code),
        .code(core_code)
    );
    //--------------------------------------------------------------
    // Bus write path
    //--------------------------------------------------------------
    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire wr_csr = do_write && (aw_addr_q == `SAC_ADDR_CSR) && w_strb_q[0];
    wire wr_mux = do_write && (aw_addr_q == `SAC_ADDR_MUX) && w_strb_q[0];
    wire rd_lo = s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == `SAC_ADDR_RLO);
    wire rd_hi = s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == `SAC_ADDR_RHI);
    wire go_wr = wr_csr && w_data_q[`SAC_GO];
    wire on_wr = wr_csr ? w_data_q[`SAC_ON] : converter_on_q;
    wire finish = busy_q && tick && (cnt_q == `SAC_ONE_CYC);
    wire restart = finish && free_run_select_q && on_wr;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SAC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_q) ? `SAC_RESP_OKAY
                    : `SAC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    //--------------------------------------------------------------
    // Bus read path
    //--------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SAC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, read_reg(s_axi_araddr)};
                s_axi_rresp <= mapped(s_axi_araddr) ? `SAC_RESP_OKAY
                    : `SAC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    //--------------------------------------------------------------
    // Configuration and conversion sequencing
    //--------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reference_select_q <= 2'b00;
            left_justify_q <= 1'b0;
            channel_select_q <= 4'h0;
            converter_on_q <= 1'b0;
            convert_go_q <= 1'b0;
            free_run_select_q <= 1'b0;
            conversion_done_flag_q <= 1'b0;
            conversion_done_irq_enable_q <= 1'b0;
            prescale_select_q <= 3'b000;
            result_q <= `SAC_RST_CODE;
            pend_valid_q <= 1'b0;
            lock_q <= 1'b0;
            first_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 5'd0;
            core_sample_q <= 1'b0;
            mux_chan_out <= 4'h0;
            mux_ref_out <= 2'b00;
            internal_ref_on <= 1'b0;
            conversion_done_irq <= 1'b0;
        end
        else
        begin
            core_sample_q <= 1'b0;
            if (wr_mux)
            begin
                reference_select_q <= w_data_q[`SAC_REF_HI:`SAC_REF_LO];
                left_justify_q <= w_data_q[`SAC_LADJ];
                channel_select_q <= w_data_q[`SAC_CH_HI:`SAC_CH_LO];
            end
            if (wr_csr)
            begin
                converter_on_q <= w_data_q[`SAC_ON];
                free_run_select_q <= w_data_q[`SAC_FREE];
                conversion_done_irq_enable_q <= w_data_q[`SAC_IE];
                prescale_select_q <= w_data_q[`SAC_PS_HI:`SAC_PS_LO];
                if (w_data_q[`SAC_ON] && !converter_on_q)
                    first_q <= 1'b1;
            end
            // Selection tracks the register until locked by a conversion
            if (!busy_q || !lock_q)
            begin
                mux_chan_out <= channel_select_q;
                mux_ref_out <= reference_select_q;
            end
            internal_ref_on <= (mux_ref_out == 2'b11);
            if (!on_wr)
            begin
                busy_q <= 1'b0;
                convert_go_q <= 1'b0;
                lock_q <= 1'b0;
            end
            else if (go_wr && !busy_q)
            begin
                convert_go_q <= 1'b1;
            end
            else if (convert_go_q && !busy_q && tick)
            begin
                busy_q <= 1'b1;
                lock_q <= 1'b1;
                cnt_q <= first_q ? `SAC_FIRST_CYC : `SAC_NORM_CYC;
                first_q <= 1'b0;
            end
            else if (busy_q && tick)
            begin
                cnt_q <= cnt_q - `SAC_ONE_CYC;
                if (cnt_q == `SAC_UNLOCK_CYC)
                begin
                    lock_q <= 1'b0;
                    core_sample_q <= 1'b1;
                end
                if (finish)
                begin
                    busy_q <= restart;
                    lock_q <= restart;
                    cnt_q <= `SAC_NORM_CYC;
                    convert_go_q <= restart;
                end
            end
            // Result update, frozen between low and high byte reads
            if (rd_lo)
                pend_valid_q <= 1'b1;
            else if (rd_hi)
                pend_valid_q <= 1'b0;
            if (finish && !(pend_valid_q && !rd_hi))
                result_q <= core_code;
            // Done flag: set wins over clear
            if (finish)
                conversion_done_flag_q <= 1'b1;
            else if (irq_vector_ack ||
                (wr_csr && w_data_q[`SAC_DONE]))
                conversion_done_flag_q <= 1'b0;
            conversion_done_irq <= conversion_done_flag_q &&
                conversion_done_irq_enable_q && global_irq_enable;
        end
    end
endmodule

// file: include/sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// Register byte addresses
`define SAC_ADDR_MUX 4'h0
`define SAC_ADDR_CSR 4'h4
`define SAC_ADDR_RLO 4'h8
`define SAC_ADDR_RHI 4'hC
// Channel and reference select fields
`define SAC_REF_HI 7
`define SAC_REF_LO 6
`define SAC_LADJ 5
`define SAC_CH_HI 3
`define SAC_CH_LO 0
// Control and status fields
`define SAC_ON 7
`define SAC_GO 6
`define SAC_FREE 5
`define SAC_DONE 4
`define SAC_IE 3
`define SAC_PS_HI 2
`define SAC_PS_LO 0
// Reset values and timing
`define SAC_RST_BYTE 8'h00
`define SAC_RST_CODE 10'h000
`define SAC_FIRST_CYC 5'd25
`define SAC_NORM_CYC 5'd13
`define SAC_ONE_CYC 5'd1
`define SAC_UNLOCK_CYC 5'd2
// Prescaler terminal counts, one less than the division factor
`define SAC_LIM_2 7'h01
`define SAC_LIM_4 7'h03
`define SAC_LIM_8 7'h07
`define SAC_LIM_16 7'h0F
`define SAC_LIM_32 7'h1F
`define SAC_LIM_64 7'h3F
`define SAC_LIM_128 7'h7F
// Core model levels in supply scale; bandgap and internal ref are arbitrary
`define SAC_CH_BANDGAP 4'hE
`define SAC_CH_GROUND 4'hF
`define SAC_BANDGAP_CODE 10'h1F7
`define SAC_INTREF_CODE 10'h20C
`define SAC_FULL_CODE 10'h3FF
`define SAC_RESP_OKAY 2'b00
`define SAC_RESP_SLVERR 2'b10
`endif

// file: rtl/sac_prescaler.v
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_prescaler
(
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [2:0] sel,
    output reg tick
);
    reg [6:0] cnt_q;
    reg [6:0] lim;
    always @*
    begin
        case (sel)
            3'd0: lim = `SAC_LIM_2;
            3'd1: lim = `SAC_LIM_2;
            3'd2: lim = `SAC_LIM_4;
            3'd3: lim = `SAC_LIM_8;
            3'd4: lim = `SAC_LIM_16;
            3'd5: lim = `SAC_LIM_32;
            3'd6: lim = `SAC_LIM_64;
            default: lim = `SAC_LIM_128;
        endcase
    end
    always @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            cnt_q <= 7'h00;
            tick <= 1'b0;
        end
        else if (cnt_q >= lim)
        begin
            cnt_q <= 7'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 7'h01;
            tick <= 1'b0;
        end
    end
endmodule

// file: rtl/sac_core_model.v
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_core_model
(
    input wire aclk,
    input wire aresetn,
    input wire sample,
    input wire [3:0] chan,
    input wire [1:0] refsel,
    input wire [79:0] ain_code,
    input wire [9:0] ref_ext_code,
    output reg [9:0] code
);
    // Inputs as fraction of 1024 of the analog supply; scale to reference
    reg [9:0] vin;
    reg [9:0] vref;
    reg [19:0] prod;
    reg [19:0] quo;
    always @*
    begin
        case (chan)
            `SAC_CH_BANDGAP: vin = `SAC_BANDGAP_CODE;
            `SAC_CH_GROUND: vin = `SAC_RST_CODE;
            default: vin = (chan[3]) ? `SAC_RST_CODE : ain_code[chan*10 +: 10];
        endcase
        case (refsel)
            2'b00: vref = ref_ext_code;
            2'b01: vref = `SAC_FULL_CODE;
            2'b11: vref = `SAC_INTREF_CODE;
            default: vref = ref_ext_code;
        endcase
        prod = {vin, 10'h000};
        quo = prod / {10'h000, vref};
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
            code <= `SAC_RST_CODE;
        else if (sample)
        begin
            if (vref == 10'h000 || vin >= vref)
                code <= `SAC_FULL_CODE;
            else
                code <= quo[9:0];
        end
    end
endmodule

// file: tb/sac_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Analog levels seen on the input pins
// ----------------------------------------
module sac_src
(
    output logic [79:0] ain_code,
    output logic [9:0] ref_ext_code
);
    logic [9:0] lvl [0:7];
    initial
    begin
        for (int i = 0; i < 8; i++)
            lvl[i] = 10'(32'h0000_007B * i + 32'h0000_0011);
    end
    always_comb
    begin
        for (int k = 0; k < 8; k++)
            ain_code[10 * k +: 10] = lvl[k];
        ref_ext_code = 10'h200;
    end
endmodule

// file: tb/sac_ctl_monitor.sv
`timescale 1ns/1ps
module sac_ctl_monitor
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire global_irq_enable,
    input wire irq_vector_ack,
    input wire conversion_done_irq,
    input wire internal_ref_on,
    input wire [1:0] mux_ref_out
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_irq_gate;
        conversion_done_irq |-> $past(global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq while globally masked");
    property p_irq_ack;
        irq_vector_ack |-> ##[1:3] !conversion_done_irq;
    endproperty
    a_irq_ack: assert property (p_irq_ack)
        else $error("irq kept after vector ack");
    property p_ref_on;
        mux_ref_out == 2'h3 && $past(mux_ref_out) == 2'h3 |-> internal_ref_on;
    endproperty
    a_ref_on: assert property (p_ref_on)
        else $error("internal reference off");
    property p_ref_off;
        mux_ref_out != 2'h3 && $past(mux_ref_out) != 2'h3 |-> !internal_ref_on;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("internal reference on");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("bvalid dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read answer not held");
    property p_rans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans)
        else $error("read answer late");
    property p_bans;
        s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans)
        else $error("write answer late");
endmodule
bind sac_adc_ctrl sac_ctl_monitor mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .global_irq_enable, .irq_vector_ack, .conversion_done_irq,
    .internal_ref_on, .mux_ref_out);

// file: tb/sar_adc_control_logic_bench.sv
`timescale 1ns/1ps
`include "sac_regs.vh"
module sar_adc_control_logic_bench;
    localparam logic [3:0] mux = `SAC_ADDR_MUX;
    localparam logic [3:0] csr = `SAC_ADDR_CSR;
    localparam logic [3:0] rlo = `SAC_ADDR_RLO;
    localparam logic [3:0] rhi = `SAC_ADDR_RHI;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, global_irq_enable;
    logic irq_vector_ack, conversion_done_irq, internal_ref_on;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, mux_chan_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, mux_ref_out, rr, wb;
    logic [79:0] ain_code;
    logic [9:0] ref_ext_code;
    integer fail_count = 0;
    integer total_checks = 0;
    integer cyc;
    sac_adc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ain_code,
        .ref_ext_code, .global_irq_enable, .irq_vector_ack,
        .conversion_done_irq, .internal_ref_on, .mux_chan_out,
        .mux_ref_out);
    sac_src src (.ain_code, .ref_ext_code);
    initial
    begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        wb = s_axi_bresp;
        s_axi_bready <= 1'h0;
    end
    endtask
    task rd(input logic [3:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    end
    endtask
    task rdchk(input logic [3:0] a, input logic [7:0] e);
    begin
        rd(a);
        chk(rv, {24'h00_0000, e});
    end
    endtask
    // Right-justified result pair, low byte first
    task res(input logic [9:0] e);
    begin
        rdchk(rlo, e[7:0]);
        rdchk(rhi, {6'h00, e[9:8]});
    end
    endtask
    task wirq;
    begin
        cyc = 0;
        while (!conversion_done_irq)
        begin
            @(posedge aclk);
            cyc = cyc + 1;
        end
    end
    endtask
    task conv(input logic [7:0] c, input integer lo, input integer hi);
    begin
        wr(csr, c);
        wirq;
        chk(32'(cyc >= lo && cyc <= hi), 32'h0000_0001);
    end
    endtask
    task t_reset;
    begin
        for (int i = 0; i < 4; i++)
            rdchk(4'(4 * i), 8'h00);
        rd(4'h2);
        chk(rr, `SAC_RESP_SLVERR);
        wr(4'h2, 8'hFF);
        chk(wb, `SAC_RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        wr(mux, 8'hFF);
        s_axi_wstrb <= 4'hF;
        chk(wb, `SAC_RESP_OKAY);
        rdchk(mux, 8'h00);
        chk({internal_ref_on, mux_chan_out, mux_ref_out}, 7'h00);
    end
    endtask
    task t_first;
    begin
        wr(mux, 8'h42);
        conv(8'hC8, 48, 58);
        rdchk(csr, 8'h98);
        chk(mux_chan_out, 4'h2);
        res(src.lvl[2]);
        wr(mux, 8'h62);
        rdchk(rlo, {src.lvl[2][1:0], 6'h00});
        rdchk(rhi, src.lvl[2][9:2]);
        wr(csr, 8'h88);
        rdchk(csr, 8'h98);
        irq_vector_ack <= 1'h1;
        @(posedge aclk);
        irq_vector_ack <= 1'h0;
        rdchk(csr, 8'h88);
    end
    endtask
    task t_presc;
        integer d;
    begin
        for (int p = 0; p < 8; p++)
        begin
            d = (p == 0) ? 2 : (1 << p);
            conv(8'hC8 | 8'(p), 13 * d - 2, 14 * d + 4);
            wr(csr, 8'h98 | 8'(p));
        end
    end
    endtask
    // Ground, bandgap, unused code 8 and the external reference
    task t_chan;
        logic [7:0] m [0:4];
        logic [9:0] e [0:4];
    begin
        m = '{8'h48, 8'h4E, 8'h4F, 8'h01, 8'hCF};
        e = '{10'h000, 10'h1F7, 10'h000, 10'h118, 10'h000};
        wr(csr, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(mux, m[i]);
            conv(8'hC8, 24, 60);
            chk(internal_ref_on, m[i][7:6] == 2'h3);
            res(e[i]);
            wr(csr, 8'h98);
        end
    end
    endtask
    task t_defer;
    begin
        wr(mux, 8'h43);
        wr(csr, 8'hCB);
        repeat (20) @(posedge aclk);
        wr(mux, 8'h45);
        chk(mux_chan_out, 4'h3);
        wr(csr, 8'h8B);
        rdchk(csr, 8'hCB);
        wirq;
        res(src.lvl[3]);
        chk(mux_chan_out, 4'h5);
        wr(csr, 8'h9B);
    end
    endtask
    task t_free;
    begin
        wr(mux, 8'h44);
        conv(8'hEB, 102, 116);
        rdchk(csr, 8'hFB);
        rdchk(rlo, 8'hFD);
        src.lvl[4] = 10'h3C5;
        repeat (300) @(posedge aclk);
        rdchk(rhi, 8'h01);
        global_irq_enable <= 1'h0;
        repeat (250) @(posedge aclk);
        chk(conversion_done_irq, 1'h0);
        rdchk(rlo, 8'hC5);
        rdchk(rhi, 8'h03);
        global_irq_enable <= 1'h1;
        wr(csr, 8'h9B);
        repeat (250) @(posedge aclk);
        rdchk(csr, 8'h9B);
    end
    endtask
    task t_abort;
    begin
        wr(csr, 8'h10);
        wr(csr, 8'hCF);
        repeat (100) @(posedge aclk);
        wr(csr, 8'h0F);
        rdchk(csr, 8'h0F);
        repeat (3500) @(posedge aclk);
        chk(conversion_done_irq, 1'h0);
    end
    endtask
    task test_done;
    begin
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    initial
    begin
        #300000;
        fail_count = fail_count + 1;
        test_done;
    end
    initial
    begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, irq_vector_ack} = 3'h0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        global_irq_enable = 1'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_first;
        t_presc;
        t_chan;
        t_defer;
        t_free;
        t_abort;
        test_done;
    end
endmodule
